// [design/cgf_byte_rx.sv]
// Link-side block write sequencer: drops header bytes, indexes data bytes
`timescale 1ns/1ps
module cgf_byte_rx #(
	parameter int MAX_DATA = cgf_pkg::MAX_DATA_BYTES
)
(
	input wire logic link_clk_in,
	input wire logic reset_in,
	input wire logic frame_start_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	cgf_wr_if.src wr
);
	logic rst_s1_q;
	logic rst_s2_q;
	cgf_pkg::cgf_rx_state_type state_q;
	cgf_pkg::cgf_rx_state_type state_d;
	logic [5:0] count_q;
	logic [5:0] count_d;
	logic [5:0] idx_q;
	logic [5:0] idx_d;
	logic tog_q;
	logic tog_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic [4:0] widx_q;
	logic [4:0] widx_d;

	// Core reset brought into the link domain
	always_ff @(posedge link_clk_in)
	begin
		rst_s1_q <= reset_in;
		rst_s2_q <= rst_s1_q;
	end

	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		idx_d = idx_q;
		tog_d = tog_q;
		data_d = data_q;
		widx_d = widx_q;
		if (frame_start_in)
		begin
			state_d = cgf_pkg::RX_CMD; // RULE_11
		end
		else if (byte_valid_in)
		begin
			unique case (state_q)
				cgf_pkg::RX_IDLE:
				begin
					state_d = cgf_pkg::RX_IDLE;
				end
				cgf_pkg::RX_CMD:
				begin
					state_d = cgf_pkg::RX_COUNT; // RULE_12
				end
				cgf_pkg::RX_COUNT:
				begin
					count_d = byte_in[5:0]; // RULE_12
					idx_d = 6'h00;
					if (byte_in == 8'h00 || byte_in > 8'(MAX_DATA))
						state_d = cgf_pkg::RX_IDLE;
					else
						state_d = cgf_pkg::RX_DATA;
				end
				cgf_pkg::RX_DATA:
				begin
					tog_d = ~tog_q; // RULE_11
					data_d = byte_in;
					widx_d = idx_q[4:0];
					idx_d = 6'(idx_q + 6'h01);
					if (6'(idx_q + 6'h01) == count_q)
						state_d = cgf_pkg::RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in)
	begin
		if (rst_s2_q)
		begin
			state_q <= cgf_pkg::RX_IDLE;
			count_q <= 6'h00;
			idx_q <= 6'h00;
			tog_q <= 1'b0;
			data_q <= 8'h00;
			widx_q <= 5'h00;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
			idx_q <= idx_d;
			tog_q <= tog_d;
			data_q <= data_d;
			widx_q <= widx_d;
		end
	end

	assign wr.wr_toggle = tog_q;
	assign wr.wr_index = widx_q;
	assign wr.wr_data = data_q;

	default clocking cb_link @(posedge link_clk_in);
	endclocking
	default disable iff (rst_s2_q);

	a_header_dropped: assert property ( // RULE_12
		(state_q == cgf_pkg::RX_CMD || state_q == cgf_pkg::RX_COUNT)
		&& byte_valid_in && !frame_start_in |=> $stable(tog_q))
	else $error("header byte was forwarded as data");

	a_data_in_order: assert property ( // RULE_11
		state_q == cgf_pkg::RX_DATA && byte_valid_in && !frame_start_in
		|=> tog_q != $past(tog_q) && widx_q == $past(idx_q[4:0])
		&& data_q == $past(byte_in))
	else $error("data byte not forwarded at its index");

	a_count_stop: assert property ( // RULE_11
		state_q == cgf_pkg::RX_DATA && byte_valid_in && !frame_start_in
		&& 6'(idx_q + 6'h01) == count_q |=> state_q == cgf_pkg::RX_IDLE)
	else $error("receiver kept taking data past the byte count");
endmodule

// [design/cgf_config_top.sv]
// Configuration bytes three to six and operating frequency selection
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Byte three enables memory nine, interrupt clocks
// [RULE_02] Override low: strap pins choose the frequency
// [RULE_03] Override high: register code chooses the frequency
// [RULE_04] Code order: bit2, then bits 7..4
// [RULE_05] Frequency code decodes centre, down or no spread
// [RULE_06] Test bit three-states every clock output
// [RULE_07] Byte four resets entirely to zero
// [RULE_08] Byte five resets entirely to zero
// [RULE_09] Byte six resets with bits 2,1 set
// [RULE_10] Disabled clock output is held low
// [RULE_11] Ascending block writes only, no indexed access
// [RULE_12] Command and count bytes are discarded
// [RULE_13] Host writes zero to reserved bits
// [RULE_14] Export effective code, spread and output enables
module cgf_config_top
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic link_clk_in,
	input wire logic link_frame_start_in,
	input wire logic link_byte_valid_in,
	input wire logic [7:0] link_byte_in,
	input wire logic [4:0] freq_strap_inputs_in,
	input wire logic mem_clk_nine_src_in,
	input wire logic int_ctrl_clk_src_in,
	output logic mem_clk_nine_out,
	output logic mem_clk_nine_oe_out,
	output logic int_ctrl_clk_out,
	output logic int_ctrl_clk_oe_out,
	output logic all_outputs_tristate_out,
	output logic memory_clock_nine_enable_out,
	output logic interrupt_ctrl_clock_enable_out,
	output logic strap_override_out,
	output logic [4:0] eff_freq_code_out,
	output cgf_pkg::cgf_spread_type spread_mode_out,
	output logic [10:0] cpu_freq_tenth_mhz_out,
	output logic cfg_wr_strobe_out,
	output logic [4:0] cfg_wr_index_out,
	output logic [7:0] cfg_wr_data_out
);
	cgf_wr_if wr_bus();

	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_seen_q;
	logic wr_seen;
	logic [4:0] strap_s1_q;
	logic [4:0] strap_s2_q;
	logic [7:0] out_en_q;
	logic [7:0] out_en_d;
	logic [7:0] fsel_q;
	logic [7:0] fsel_d;
	logic [7:0] spare_zero_q;
	logic [7:0] spare_zero_d;
	logic [7:0] spare_preset_q;
	logic [7:0] spare_preset_d;
	logic [4:0] reg_code;
	logic [4:0] code_q;
	logic [4:0] code_d;
	cgf_pkg::cgf_spread_type spread_q;
	cgf_pkg::cgf_spread_type spread_d;
	logic [10:0] cpu_q;
	logic [10:0] cpu_d;
	logic wr_stb_q;
	logic wr_stb_d;
	logic [4:0] wr_idx_q;
	logic [4:0] wr_idx_d;
	logic [7:0] wr_data_q;
	logic [7:0] wr_data_d;

	cgf_byte_rx #(
		.MAX_DATA(cgf_pkg::MAX_DATA_BYTES)
	) u_rx (
		.link_clk_in(link_clk_in),
		.reset_in(reset_in),
		.frame_start_in(link_frame_start_in),
		.byte_valid_in(link_byte_valid_in),
		.byte_in(link_byte_in),
		.wr(wr_bus.src)
	);

	// Spread setting belonging to each frequency code
	function automatic cgf_pkg::cgf_spread_type spread_of(
		input logic [4:0] c);
		if (c[4:2] == 3'b011)
			spread_of = cgf_pkg::SPREAD_CENTRE;
		else if (c == 5'h01 || c == 5'h13 || c == 5'h15 || c[4:2] == 3'b111)
			spread_of = cgf_pkg::SPREAD_DOWN;
		else
			spread_of = cgf_pkg::SPREAD_OFF;
	endfunction

	// Processor clock for each code, in tenths of a MHz
	function automatic logic [10:0] cpu_of(input logic [4:0] c);
		unique case (c)
			5'h00: cpu_of = 11'h2f1;
			5'h01: cpu_of = 11'h3b6;
			5'h02: cpu_of = 11'h50a;
			5'h03: cpu_of = 11'h5dc;
			5'h04: cpu_of = 11'h5dc;
			5'h05: cpu_of = 11'h44c;
			5'h06: cpu_of = 11'h578;
			5'h07: cpu_of = 11'h5a0;
			5'h08: cpu_of = 11'h2ab;
			5'h09: cpu_of = 11'h41a;
			5'h0a: cpu_of = 11'h564;
			5'h0b: cpu_of = 11'h578;
			5'h0c: cpu_of = 11'h29c;
			5'h0d: cpu_of = 11'h3ea;
			5'h0e: cpu_of = 11'h538;
			5'h0f: cpu_of = 11'h538;
			5'h10: cpu_of = 11'h625;
			5'h11: cpu_of = 11'h640;
			5'h12: cpu_of = 11'h5ba;
			5'h13: cpu_of = 11'h4c4;
			5'h14: cpu_of = 11'h4f6;
			5'h15: cpu_of = 11'h4c4;
			5'h16: cpu_of = 11'h492;
			5'h17: cpu_of = 11'h474;
			5'h18: cpu_of = 11'h320;
			5'h19: cpu_of = 11'h30c;
			5'h1a: cpu_of = 11'h67c;
			5'h1b: cpu_of = 11'h538;
			5'h1c: cpu_of = 11'h29a;
			5'h1d: cpu_of = 11'h3e8;
			5'h1e: cpu_of = 11'h535;
			5'h1f: cpu_of = 11'h535;
		endcase
	endfunction

	// Write toggle and strap pins enter the core domain
	always_ff @(posedge core_clk_in)
	begin
		tog_s1_q <= wr_bus.wr_toggle;
		tog_s2_q <= tog_s1_q;
		strap_s1_q <= freq_strap_inputs_in;
		strap_s2_q <= strap_s1_q;
	end

	// Index and data update on the same link edge that flips the toggle
	assign wr_seen = tog_s2_q ^ tog_seen_q;

	assign reg_code = {fsel_q[cgf_pkg::FREQ_CODE_BIT_FOUR_POS],
		fsel_q[cgf_pkg::CODE_LOW_MSB:cgf_pkg::CODE_LOW_LSB]}; // RULE_04

	always_comb
	begin
		out_en_d = out_en_q;
		fsel_d = fsel_q;
		spare_zero_d = spare_zero_q;
		spare_preset_d = spare_preset_q;
		wr_stb_d = 1'b0;
		wr_idx_d = wr_idx_q;
		wr_data_d = wr_data_q;
		if (wr_seen)
		begin
			if (wr_bus.wr_index == cgf_pkg::OFS_EXTRA_OUTPUT_ENABLES)
				out_en_d = wr_bus.wr_data; // RULE_01
			if (wr_bus.wr_index == cgf_pkg::OFS_FREQUENCY_SELECT_CONTROL)
				fsel_d = wr_bus.wr_data;
			if (wr_bus.wr_index == cgf_pkg::OFS_SPARE_ZERO_BYTE)
				spare_zero_d = wr_bus.wr_data;
			if (wr_bus.wr_index == cgf_pkg::OFS_SPARE_PRESET_BYTE)
				spare_preset_d = wr_bus.wr_data;
			// Lower bytes belong to neighbouring register blocks
			if (wr_bus.wr_index < cgf_pkg::OFS_FIRST_LOCAL)
			begin
				wr_stb_d = 1'b1;
				wr_idx_d = wr_bus.wr_index;
				wr_data_d = wr_bus.wr_data;
			end
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			tog_seen_q <= 1'b0;
			out_en_q <= cgf_pkg::RST_EXTRA_OUTPUT_ENABLES; // RULE_01
			fsel_q <= cgf_pkg::RST_FREQUENCY_SELECT_CONTROL; // RULE_07
			spare_zero_q <= cgf_pkg::RST_SPARE_ZERO_BYTE; // RULE_08
			spare_preset_q <= cgf_pkg::RST_SPARE_PRESET_BYTE; // RULE_09
			wr_stb_q <= 1'b0;
			wr_idx_q <= 5'h00;
			wr_data_q <= 8'h00;
		end
		else
		begin
			tog_seen_q <= tog_s2_q;
			out_en_q <= out_en_d;
			fsel_q <= fsel_d;
			spare_zero_q <= spare_zero_d;
			spare_preset_q <= spare_preset_d;
			wr_stb_q <= wr_stb_d;
			wr_idx_q <= wr_idx_d;
			wr_data_q <= wr_data_d;
		end
	end

	always_comb
	begin
		if (fsel_q[cgf_pkg::STRAP_OVERRIDE_BIT])
			code_d = reg_code; // RULE_03
		else
			code_d = strap_s2_q; // RULE_02
		spread_d = spread_of(code_q); // RULE_05
		cpu_d = cpu_of(code_q); // RULE_04
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			code_q <= 5'h00;
			spread_q <= cgf_pkg::SPREAD_OFF;
			cpu_q <= 11'h000;
		end
		else
		begin
			code_q <= code_d;
			spread_q <= spread_d;
			cpu_q <= cpu_d;
		end
	end

	// Disabled clocks are driven low; test mode releases every pin
	assign mem_clk_nine_out = mem_clk_nine_src_in
		& out_en_q[cgf_pkg::MEM_CLK_NINE_EN_BIT]; // RULE_10
	assign int_ctrl_clk_out = int_ctrl_clk_src_in
		& out_en_q[cgf_pkg::INT_CTRL_CLK_EN_BIT]; // RULE_10
	assign mem_clk_nine_oe_out =
		~fsel_q[cgf_pkg::TEST_TRISTATE_BIT]; // RULE_06
	assign int_ctrl_clk_oe_out =
		~fsel_q[cgf_pkg::TEST_TRISTATE_BIT]; // RULE_06
	assign all_outputs_tristate_out = fsel_q[cgf_pkg::TEST_TRISTATE_BIT];
	assign memory_clock_nine_enable_out =
		out_en_q[cgf_pkg::MEM_CLK_NINE_EN_BIT]; // RULE_14
	assign interrupt_ctrl_clock_enable_out =
		out_en_q[cgf_pkg::INT_CTRL_CLK_EN_BIT]; // RULE_14
	assign strap_override_out = fsel_q[cgf_pkg::STRAP_OVERRIDE_BIT];
	assign eff_freq_code_out = code_q; // RULE_14
	assign spread_mode_out = spread_q; // RULE_14
	assign cpu_freq_tenth_mhz_out = cpu_q;
	assign cfg_wr_strobe_out = wr_stb_q;
	assign cfg_wr_index_out = wr_idx_q;
	assign cfg_wr_data_out = wr_data_q;

	default clocking cb_core @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);

	sequence s_local_write(logic [4:0] ofs);
		wr_seen && wr_bus.wr_index == ofs;
	endsequence

	a_enables_written: assert property ( // RULE_01
		s_local_write(cgf_pkg::OFS_EXTRA_OUTPUT_ENABLES)
		|=> out_en_q == $past(wr_bus.wr_data))
	else $error("byte three write did not land");

	a_strap_chosen: assert property ( // RULE_02
		!fsel_q[cgf_pkg::STRAP_OVERRIDE_BIT] |=> code_q == $past(strap_s2_q))
	else $error("strap pins not used while override is low");

	a_reg_code_chosen: assert property ( // RULE_03
		fsel_q[cgf_pkg::STRAP_OVERRIDE_BIT]
		|=> code_q == {$past(fsel_q[2]), $past(fsel_q[7:4])})
	else $error("register code not used while override is high");

	a_code_to_spread: assert property ( // RULE_05
		code_q[4:2] == 3'b011 |=> spread_q == cgf_pkg::SPREAD_CENTRE)
	else $error("centre spread not selected");

	a_down_spread: assert property ( // RULE_05
		(code_q == 5'h01 || code_q == 5'h13 || code_q == 5'h15
		|| code_q[4:2] == 3'b111) |=> spread_q == cgf_pkg::SPREAD_DOWN)
	else $error("down spread not selected");

	a_no_spread: assert property ( // RULE_05
		code_q == 5'h00 || code_q == 5'h10 ##1 1'b1
		|-> spread_q == cgf_pkg::SPREAD_OFF)
	else $error("spread on for a code without spread");

	a_test_tristate: assert property ( // RULE_06
		fsel_q[cgf_pkg::TEST_TRISTATE_BIT]
		|-> !mem_clk_nine_oe_out && !int_ctrl_clk_oe_out)
	else $error("outputs driven while test bit is set");

	a_disabled_low: assert property ( // RULE_10
		!out_en_q[cgf_pkg::MEM_CLK_NINE_EN_BIT]
		&& !fsel_q[cgf_pkg::TEST_TRISTATE_BIT]
		|-> mem_clk_nine_oe_out && !mem_clk_nine_out)
	else $error("disabled memory clock not held low");

	a_reset_values: assert property ( // RULE_07
		$past(reset_in) |-> out_en_q == cgf_pkg::RST_EXTRA_OUTPUT_ENABLES
		&& fsel_q == cgf_pkg::RST_FREQUENCY_SELECT_CONTROL
		&& spare_zero_q == cgf_pkg::RST_SPARE_ZERO_BYTE
		&& spare_preset_q == cgf_pkg::RST_SPARE_PRESET_BYTE)
	else $error("configuration bytes not at reset values");

	a_spare_zero_written: assert property ( // RULE_08
		s_local_write(cgf_pkg::OFS_SPARE_ZERO_BYTE)
		|=> spare_zero_q == $past(wr_bus.wr_data))
	else $error("byte five write did not land");

	a_spare_preset_written: assert property ( // RULE_09
		s_local_write(cgf_pkg::OFS_SPARE_PRESET_BYTE)
		|=> spare_preset_q == $past(wr_bus.wr_data))
	else $error("byte six write did not land");

	a_foreign_strobe: assert property ( // RULE_14
		wr_seen && wr_bus.wr_index < cgf_pkg::OFS_FIRST_LOCAL
		|=> cfg_wr_strobe_out ##1 !cfg_wr_strobe_out)
	else $error("lower byte write not passed on as one pulse");
endmodule

// [shared/cgf_pkg.sv]
// Shared constants and types for the clock generator configuration block
package cgf_pkg;
	// Width of a data byte index within one block write
	localparam int IDX_W = 5;
	// Most data bytes one block write may carry
	localparam int MAX_DATA_BYTES = 32;

	// Byte indices of the registers held here
	localparam logic [4:0] OFS_EXTRA_OUTPUT_ENABLES = 5'h03;
	localparam logic [4:0] OFS_FREQUENCY_SELECT_CONTROL = 5'h04;
	localparam logic [4:0] OFS_SPARE_ZERO_BYTE = 5'h05;
	localparam logic [4:0] OFS_SPARE_PRESET_BYTE = 5'h06;
	// Lowest index that belongs to this block
	localparam logic [4:0] OFS_FIRST_LOCAL = 5'h03;

	// Field positions in extra_output_enables
	localparam int MEM_CLK_NINE_EN_BIT = 7;
	localparam int INT_CTRL_CLK_EN_BIT = 3;
	// Field positions in frequency_select_control
	localparam int CODE_LOW_MSB = 7;
	localparam int CODE_LOW_LSB = 4;
	localparam int STRAP_OVERRIDE_BIT = 3;
	localparam int FREQ_CODE_BIT_FOUR_POS = 2;
	localparam int TEST_TRISTATE_BIT = 0;

	// Reset values
	localparam logic [7:0] RST_EXTRA_OUTPUT_ENABLES = 8'h8a;
	localparam logic [7:0] RST_FREQUENCY_SELECT_CONTROL = 8'h00;
	localparam logic [7:0] RST_SPARE_ZERO_BYTE = 8'h00;
	localparam logic [7:0] RST_SPARE_PRESET_BYTE = 8'h06;

	typedef enum logic [1:0]
	{
		SPREAD_OFF = 2'b00,
		SPREAD_CENTRE = 2'b01,
		SPREAD_DOWN = 2'b10
	} cgf_spread_type;

	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_CMD = 2'b01,
		RX_COUNT = 2'b10,
		RX_DATA = 2'b11
	} cgf_rx_state_type;
endpackage

// [shared/cgf_wr_if.sv]
// Byte write path from the link-side receiver to the core registers
`timescale 1ns/1ps
interface cgf_wr_if;
	logic wr_toggle;
	logic [4:0] wr_index;
	logic [7:0] wr_data;

	modport src
	(
		output wr_toggle,
		output wr_index,
		output wr_data
	);
	modport dst
	(
		input wr_toggle,
		input wr_index,
		input wr_data
	);
endinterface

// [sim/cgf_host_model.sv]
// Host side block write driver on the serial link
`timescale 1ns/1ps
module cgf_host_model
(
	output logic link_clk_out,
	output logic frame_start_out,
	output logic byte_valid_out,
	output logic [7:0] byte_out
);
	initial
	begin
		link_clk_out = 1'b0;
		frame_start_out = 1'b0;
		byte_valid_out = 1'b0;
		byte_out = 8'h5a;
	end

	// One link cycle; idle byte lines show the inverse of the last value
	task automatic cyc(input logic fs, input logic v, input logic [7:0] b);
		#32 link_clk_out = 1'b1;
		frame_start_out <= fs;
		byte_valid_out <= v;
		byte_out <= v ? b : ~byte_out;
		#32 link_clk_out = 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 8'h00);
	endtask

	// Frame, command, count, then data ascending; link clock stops after
	task automatic send(input logic [7:0] cnt, input logic [7:0] d[$],
		input int gap);
		cyc(1'b1, 1'b0, 8'h00);
		cyc(1'b0, 1'b1, 8'h00);
		idle(gap);
		cyc(1'b0, 1'b1, cnt);
		foreach (d[i])
		begin
			idle(gap);
			cyc(1'b0, 1'b1, d[i]);
		end
		idle(3);
	endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the configuration and frequency select block
`timescale 1ns/1ps
module testbench;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic link_clk, fs, bv;
	logic [7:0] lb;
	logic [4:0] strap = 5'h00;
	logic src9 = 1'b0;
	logic srci = 1'b0;
	logic mclk, moe, iclk, ioe, tri3, men, ien, ovr, wr_s;
	logic [4:0] code, wr_i;
	logic [7:0] wr_d;
	logic [10:0] cpu;
	cgf_pkg::cgf_spread_type spr;
	logic [31:0] lf = 32'hc5db;
	logic [12:0] wr_q[$];
	logic [7:0] dq[$];
	logic [4:0] c;
	int b3, b4, err_count, samples_checked, cycles;
	int cpu_tab[32] = '{753, 950, 1290, 1500, 1500, 1100, 1400, 1440,
		683, 1050, 1380, 1400, 668, 1002, 1336, 1336, 1573, 1600, 1466,
		1220, 1270, 1220, 1170, 1140, 800, 780, 1660, 1336, 666, 1000,
		1333, 1333};

	always #4 core_clk_in = ~core_clk_in;

	cgf_host_model u_cgf_host_model
	(
		.link_clk_out(link_clk),
		.frame_start_out(fs),
		.byte_valid_out(bv),
		.byte_out(lb)
	);

	cgf_config_top u_cgf_config_top
	(
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.link_clk_in(link_clk),
		.link_frame_start_in(fs),
		.link_byte_valid_in(bv),
		.link_byte_in(lb),
		.freq_strap_inputs_in(strap),
		.mem_clk_nine_src_in(src9),
		.int_ctrl_clk_src_in(srci),
		.mem_clk_nine_out(mclk),
		.mem_clk_nine_oe_out(moe),
		.int_ctrl_clk_out(iclk),
		.int_ctrl_clk_oe_out(ioe),
		.all_outputs_tristate_out(tri3),
		.memory_clock_nine_enable_out(men),
		.interrupt_ctrl_clock_enable_out(ien),
		.strap_override_out(ovr),
		.eff_freq_code_out(code),
		.spread_mode_out(spr),
		.cpu_freq_tenth_mhz_out(cpu),
		.cfg_wr_strobe_out(wr_s),
		.cfg_wr_index_out(wr_i),
		.cfg_wr_data_out(wr_d)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic int spread_of(input int k);
		if (k >= 12 && k <= 15)
			return 1;
		if (k == 1 || k == 19 || k == 21 || k >= 28)
			return 2;
		return 0;
	endfunction

	// Raw clock sources get random levels so the gating is exercised
	always @(posedge core_clk_in)
	begin
		lf <= lfsr(lf);
		src9 <= lf[0];
		srci <= lf[5];
		if (wr_s === 1'b1)
			wr_q.push_back({wr_i, wr_d});
		cycles++;
		if (cycles == 30000)
		begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	task automatic check_all;
		int k;
		k = b4[3] ? {b4[2], b4[7:4]} : strap;
		chk(men, b3[7]);
		chk(ien, b3[3]);
		chk(ovr, b4[3]);
		chk(tri3, b4[0]);
		chk(moe, !b4[0]);
		chk(ioe, !b4[0]);
		chk(code, k);
		chk(spr, spread_of(k));
		chk(cpu, cpu_tab[k]);
		chk(mclk, src9 & b3[7]);
		chk(iclk, srci & b3[3]);
	endtask

	task automatic do_reset;
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		u_cgf_host_model.idle(4);
		@(posedge core_clk_in);
		reset_in <= 1'b0;
		u_cgf_host_model.idle(3);
		b3 = 8'h8a;
		b4 = 0;
		wt(6);
	endtask

	task automatic frame(input int cnt, input logic [7:0] d[$],
		input int gap);
		int n;
		n = (cnt >= 1 && cnt <= 32) ? ((cnt < d.size()) ? cnt : d.size()) : 0;
		wr_q = {};
		u_cgf_host_model.send(cnt[7:0], d, gap);
		wt(10);
		if (n > 3)
			b3 = d[3];
		if (n > 4)
			b4 = d[4];
		chk(wr_q.size(), (n < 3) ? n : 3);
		foreach (wr_q[i])
			chk(wr_q[i], {i[4:0], d[i]});
		check_all();
	endtask

	initial
	begin
		do_reset();
		check_all();
		for (int k = 0; k < 32; k++)
		begin
			@(posedge core_clk_in);
			strap <= k[4:0];
			wt(6);
			check_all();
		end
		for (int k = 0; k < 32; k++)
		begin
			c = k[4:0];
			@(posedge core_clk_in);
			strap <= ~c;
			dq = '{lf[7:0], lf[15:8], lf[23:16], {k[0], 3'h0, k[1], 3'h0},
				{c[3:0], 1'b1, c[4], 1'b0, k[2]}};
			frame(5, dq, k[0] ? 3 : 1);
		end
		// Frame cut after two data bytes; the next frame restarts it
		dq = '{lf[7:0], lf[15:8]};
		frame(5, dq, 3);
		// Full frame reaching the spare bytes and one index beyond them
		dq = '{lf[7:0], lf[15:8], lf[23:16], lf[7:0] & 8'h88,
			lf[15:8] & 8'hfd, 8'h00, 8'h00, lf[31:24]};
		frame(8, dq, 1);
		dq = '{8'h11, 8'h22, 8'h33, 8'h08, 8'h08};
		frame(4, dq, 1);
		frame(0, dq, 1);
		frame(40, dq, 1);
		dq[4] = 8'h00;
		frame(5, dq, 1);
		dq[4] = 8'h39;
		frame(5, dq, 1);
		do_reset();
		check_all();
		print_verdict();
	end
endmodule
